// file: hbs_board_model.sv
/* board model: supplies ramp while enabled, slow tick source
   assumes the enable pin feeds the regulators directly */
`timescale 1ns/1ps
module hbs_board_model (
  input  wire sys_clk_i,   // system clock
  input  wire rstn_i,      // reset, active low
  input  wire supply_i,    // regulator enable
  input  wire slow_i,      // slow ramp
  output reg  tick_o,      // slow tick, shortened period
  output wire core_good_o, // core supply stable
  output wire io_good_o    // 3.3 V supply stable
);
  reg [4:0] ramp;
  reg [2:0] div;
  assign core_good_o = supply_i && ramp >= (slow_i ? 5'h14 : 5'h02);
  assign io_good_o   = supply_i && ramp > (slow_i ? 5'h14 : 5'h03);
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ramp   <= 5'h00;
      div    <= 3'h0;
      tick_o <= 1'h0;
    end else begin
      div    <= div + 3'h1;
      tick_o <= (div == 3'h7);
      ramp   <= !supply_i ? 5'h00 : ramp + {4'h0, ramp != 5'h1f};
    end
  end
endmodule // hbs_board_model

// file: hbs_boot_seq.v
/*
  Hibernation timer plus power-up boot sequencer with a write-once
  fuse array that trims, selects package and memory size at boot.
  Assumes all inputs synchronous to sys_clk_i; regulator good inputs
  come from the analog supplies; powered-down logic is held in reset
  through soc_rstn_o.
*/
// Summary of operation
// - on request, wake regulator output low for wake-count slow ticks.
// - on expiry, wake regulator output returns high.
// - only hibernation unit and fuse array state survive; everything else reinitialises.
// - boot starts on regulator-on or wake request input.
// - wait for core and 3.3 V regulators to be stable.
// - then apply fuse contents: trim, package and memory size.
// - power cores, then crystal, then release both CPUs.
// - fuse array holds 6144 bits readable after reset.
// - unprogrammed fuse bits read zero.
// - programmed ones never return to zero.
// - program whole array in one cycle or selected bytes over many.
`timescale 1ns/1ps
`include "hbs_consts.vh"

module hbs_boot_seq #(
  parameter WAKE_W   = `HBS_WAKE_W,
  parameter FUSE_AW  = `HBS_FUSE_AW,
  parameter FUSE_DW  = `HBS_FUSE_DW,
  parameter FUSE_N   = `HBS_FUSE_BYTES
) (
  input  wire               sys_clk_i,       // system clock, 20 MHz
  input  wire               rstn_i,          // async reset, active low
  input  wire               slow_tick_i,     // 32 kHz tick pulse
  input  wire               wake_load_i,     // load wake count
  input  wire [WAKE_W-1:0]  wake_count_i,    // wake count
  input  wire               hibernate_req_i, // request hibernation
  input  wire               regulator_on_i,  // board regulator-on level
  input  wire               wake_request_in_i, // wake request input level
  input  wire               core_reg_good_i, // core regulator stable
  input  wire               io_reg_good_i,   // 3.3 V regulator stable
  input  wire               fuse_wr_i,       // fuse program strobe
  input  wire               fuse_all_i,      // program every byte this cycle
  input  wire [FUSE_AW-1:0] fuse_addr_i,     // fuse byte address
  input  wire [FUSE_DW-1:0] fuse_wdata_i,    // bits to set
  input  wire               fuse_rd_i,       // fuse read strobe
  output reg  [FUSE_DW-1:0] fuse_rdata_o,    // fuse read data
  output reg                fuse_rvalid_o,   // read data valid pulse
  output reg                wake_reg_out_o,  // wake regulator output
  output reg                hibernate_act_o, // hibernation in progress
  output reg  [FUSE_DW-1:0] pmu_trim_o,      // power management trim
  output reg  [FUSE_DW-1:0] pkg_sel_o,       // package selection
  output reg  [FUSE_DW-1:0] mem_size_o,      // memory size selection
  output reg                core_pwr_o,      // app and wireless cores on
  output reg                xtal_en_o,       // crystal oscillator on
  output reg                cpu_run_o,       // both CPUs released
  output reg                soc_rstn_o,      // reset to non-retained logic
  output reg  [2:0]         boot_state_o     // sequencer state
);

  localparam S_OFF   = 3'd0;
  localparam S_REG   = 3'd1;
  localparam S_FUSE  = 3'd2;
  localparam S_CORE  = 3'd3;
  localparam S_XTAL  = 3'd4;
  localparam S_RUN   = 3'd5;

  wire              timer_wake;
  wire              timer_act;
  reg  [FUSE_DW-1:0] fuse_mem [0:FUSE_N-1];
  reg  [2:0]        state;
  reg  [2:0]        next_state;
  reg  [7:0]        dly;
  reg  [1:0]        fidx;
  wire              power_req;
  reg               next_core_pwr;
  reg               next_xtal_en;
  reg               next_cpu_run;

  hbs_hib_timer #(
    .WAKE_W(WAKE_W)
  ) u_timer (
    .sys_clk_i      (sys_clk_i),
    .rstn_i         (rstn_i),
    .slow_tick_i    (slow_tick_i),
    .wake_load_i    (wake_load_i),
    .wake_count_i   (wake_count_i),
    .hibernate_req_i(hibernate_req_i),
    .wake_reg_out_o (timer_wake),
    .hibernate_act_o(timer_act)
  );

  assign power_req = regulator_on_i | wake_request_in_i;

  // 768-byte array; fuses survive reset, not cleared by it
  integer i;
  initial begin
    for (i = 0; i < FUSE_N; i = i + 1) begin
      fuse_mem[i] = {FUSE_DW{1'b0}};
    end
  end

  // one write port per byte so a whole-array burn takes one cycle
  genvar g;
  generate
    for (g = 0; g < FUSE_N; g = g + 1) begin : g_fuse
      always @(posedge sys_clk_i) begin
        // whole array or one selected byte
        if (fuse_wr_i && (fuse_all_i || {{(32-FUSE_AW){1'b0}}, fuse_addr_i} == g)) begin
          fuse_mem[g] <= fuse_mem[g] | fuse_wdata_i;
        end
      end
    end
  endgenerate

  always @* begin
    next_state = state;
    case (state)
      S_OFF:  if (power_req) next_state = S_REG;
      // both regulators stable
      // limitation: a supply that dips later is not rechecked
      S_REG:  if (core_reg_good_i && io_reg_good_i) next_state = S_FUSE;
      S_FUSE: if (fidx == 2'd2) next_state = S_CORE;
      S_CORE: if (dly == `HBS_CORE_DLY) next_state = S_XTAL;
      S_XTAL: if (dly == `HBS_XTAL_DLY) next_state = S_RUN;
      S_RUN:  next_state = S_RUN;
      default: next_state = S_OFF;
    endcase
    // supply gone or hibernating: everything but the timer and the fuse array restarts
    if (!power_req || timer_act) next_state = S_OFF;
  end

  // cores, then crystal, then CPUs, as the state advances
  always @* begin
    next_core_pwr = 1'b0;
    next_xtal_en  = 1'b0;
    next_cpu_run  = 1'b0;
    case (next_state)
      S_CORE: begin
        next_core_pwr = 1'b1;
      end
      S_XTAL: begin
        next_core_pwr = 1'b1;
        next_xtal_en  = 1'b1;
      end
      S_RUN: begin
        next_core_pwr = 1'b1;
        next_xtal_en  = 1'b1;
        next_cpu_run  = 1'b1;
      end
      default: begin
        next_core_pwr = 1'b0;
      end
    endcase
  end

  // timed states only, so an idle count cannot wrap into a false match
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly <= 8'h00;
    end else if (next_state != state) begin
      dly <= 8'h00;
    end else if (state == S_CORE || state == S_XTAL) begin
      dly <= dly + 8'h01;
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state          <= S_OFF;
      fidx           <= 2'd0;
      pmu_trim_o     <= 8'h00;
      pkg_sel_o      <= 8'h00;
      mem_size_o     <= 8'h00;
      core_pwr_o     <= 1'b0;
      xtal_en_o      <= 1'b0;
      cpu_run_o      <= 1'b0;
      soc_rstn_o     <= 1'b0;
      boot_state_o   <= S_OFF;
      wake_reg_out_o <= 1'b1;
      hibernate_act_o <= 1'b0;
      fuse_rdata_o   <= 8'h00;
      fuse_rvalid_o  <= 1'b0;
    end else begin
      state          <= next_state;
      boot_state_o   <= next_state;
      wake_reg_out_o <= timer_wake;
      hibernate_act_o <= timer_act;
      fuse_rvalid_o  <= fuse_rd_i;
      if (fuse_rd_i) begin
        fuse_rdata_o <= fuse_mem[fuse_addr_i];
      end
      if (next_state == S_OFF) begin
        fidx       <= 2'd0;
        pmu_trim_o <= 8'h00;
        pkg_sel_o  <= 8'h00;
        mem_size_o <= 8'h00;
        core_pwr_o <= 1'b0;
        xtal_en_o  <= 1'b0;
        cpu_run_o  <= 1'b0;
        soc_rstn_o <= 1'b0;
      end else begin
        if (state == S_FUSE) begin
          case (fidx)
            2'd0:    pmu_trim_o <= fuse_mem[`HBS_TRIM_BYTE];
            2'd1:    pkg_sel_o  <= fuse_mem[`HBS_PKG_BYTE];
            default: mem_size_o <= fuse_mem[`HBS_MEM_BYTE];
          endcase
          fidx <= fidx + 2'd1;
        end
        core_pwr_o <= next_core_pwr;
        xtal_en_o  <= next_xtal_en;
        cpu_run_o  <= next_cpu_run;
        soc_rstn_o <= next_cpu_run;
      end
    end
  end

endmodule // hbs_boot_seq

// file: hbs_consts.vh
/*
  Shared constants for the hibernation and boot sequencer block.
  Assumes it is included by bare name from the design files.
*/
`ifndef HBS_CONSTS_VH
`define HBS_CONSTS_VH

`define HBS_WAKE_W        32
`define HBS_FUSE_BITS     6144
`define HBS_FUSE_BYTES    768
`define HBS_FUSE_AW       10
`define HBS_FUSE_DW       8
`define HBS_TRIM_BYTE     10'h000
`define HBS_PKG_BYTE      10'h001
`define HBS_MEM_BYTE      10'h002
`define HBS_CORE_DLY      8'h04
`define HBS_XTAL_DLY      8'h08
`define HBS_WAKE_RESET    32'h0000_0000

`endif

// file: hbs_hib_timer.v
/*
  Always-on hibernation timer: load a wake count, request hibernation,
  hold the regulator enable low for that many slow-clock ticks.
  Assumes slow_tick_i is a one-cycle pulse per 32 kHz period,
  synchronous to sys_clk_i; this logic sits on the always-on supply.
*/
`timescale 1ns/1ps
`include "hbs_consts.vh"

module hbs_hib_timer #(
  parameter WAKE_W = `HBS_WAKE_W
) (
  input  wire              sys_clk_i,       // always-on clock
  input  wire              rstn_i,          // async reset, active low
  input  wire              slow_tick_i,     // 32 kHz tick pulse
  input  wire              wake_load_i,     // load wake count strobe
  input  wire [WAKE_W-1:0] wake_count_i,    // wake count value
  input  wire              hibernate_req_i, // hibernation request pulse
  output reg               wake_reg_out_o,  // regulator enable, low in hibernation
  output reg               hibernate_act_o  // hibernation in progress
);

  reg [WAKE_W-1:0] wake_count;
  reg [WAKE_W-1:0] remain;

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_count      <= `HBS_WAKE_RESET;
      remain          <= `HBS_WAKE_RESET;
      wake_reg_out_o  <= 1'b1;
      hibernate_act_o <= 1'b0;
    end else begin
      if (wake_load_i && !hibernate_act_o) begin
        wake_count <= wake_count_i;
      end
      if (!hibernate_act_o) begin
        // zero count would wrap and hold the output low for 2^32 ticks; ignore it
        if (hibernate_req_i && wake_count != `HBS_WAKE_RESET) begin
          hibernate_act_o <= 1'b1;
          wake_reg_out_o  <= 1'b0;
          remain          <= wake_count;
        end
      end else if (slow_tick_i) begin
        if (remain == {{(WAKE_W-1){1'b0}}, 1'b1}) begin
          hibernate_act_o <= 1'b0;
          wake_reg_out_o  <= 1'b1;
          remain          <= `HBS_WAKE_RESET;
        end else begin
          remain <= remain - {{(WAKE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // hbs_hib_timer

// file: hbs_monitor.sv
/* port checker for hbs_boot_seq
   assumes one clock and an async active-low reset */
`timescale 1ns/1ps
module hbs_monitor (
  input wire sys_clk_i,         // clock
  input wire rstn_i,            // reset, active low
  input wire hibernate_req_i,   // hibernation request
  input wire regulator_on_i,    // regulator-on level
  input wire wake_request_in_i, // wake level
  input wire core_reg_good_i,   // core supply stable
  input wire io_reg_good_i,     // 3.3 V supply stable
  input wire fuse_rd_i,         // fuse read strobe
  input wire fuse_rvalid_o,     // read valid
  input wire wake_reg_out_o,    // wake regulator output
  input wire hibernate_act_o,   // hibernating
  input wire core_pwr_o,        // cores on
  input wire xtal_en_o,         // crystal on
  input wire cpu_run_o,         // cpus released
  input wire soc_rstn_o         // reset to lost logic
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_low_cause: assert property ($fell(wake_reg_out_o) |->
    $past(hibernate_req_i, 2) || $past(hibernate_req_i, 3)) else $error("wake output fell unasked");
  a_wake_pair: assert property (wake_reg_out_o == !hibernate_act_o)
    else $error("wake output disagrees with hibernation");
  a_sleep_cores_off: assert property (hibernate_act_o |=> !core_pwr_o)
    else $error("cores on in hibernation");
  a_soc_pair: assert property (soc_rstn_o == cpu_run_o)
    else $error("soc reset not with cpu release");
  a_boot_req: assert property (core_pwr_o |->
    $past(regulator_on_i || wake_request_in_i)) else $error("boot without request");
  a_core_good: assert property ($rose(core_pwr_o) |->
    $past(core_reg_good_i && io_reg_good_i, 2)) else $error("cores before supplies");
  a_xtal_order: assert property ($rose(xtal_en_o) |-> $past(core_pwr_o, 2))
    else $error("crystal before cores");
  a_cpu_order: assert property ($rose(cpu_run_o) |-> $past(xtal_en_o, 4))
    else $error("cpu before crystal");
  a_read_valid: assert property (fuse_rvalid_o == $past(fuse_rd_i))
    else $error("read valid timing");
endmodule // hbs_monitor

bind hbs_boot_seq hbs_monitor u_hbs_monitor (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .hibernate_req_i(hibernate_req_i), .regulator_on_i(regulator_on_i),
  .wake_request_in_i(wake_request_in_i), .core_reg_good_i(core_reg_good_i),
  .io_reg_good_i(io_reg_good_i), .fuse_rd_i(fuse_rd_i), .fuse_rvalid_o(fuse_rvalid_o),
  .wake_reg_out_o(wake_reg_out_o), .hibernate_act_o(hibernate_act_o), .core_pwr_o(core_pwr_o),
  .xtal_en_o(xtal_en_o), .cpu_run_o(cpu_run_o), .soc_rstn_o(soc_rstn_o));

// file: testbench.sv
/* self-checking bench for hbs_boot_seq
   assumes the board model closes the regulator loop */
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rstn = 0, ld = 0, req = 0, wr = 0, all = 0, rd = 0, en = 1, wk = 0, slow = 0;
  logic [31:0] cnt = 0;
  logic [9:0]  addr = 0;
  logic [7:0]  wd = 0, rdat, trim, pkg, mem;
  logic        tick, cg, ig, rvld, wro, hact, cpw, xen, run, srst;
  logic [2:0]  st;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  wire         sup = (wro & en) | wk;
  always #25 clk = ~clk;
  hbs_board_model u_hbs_board_model (.sys_clk_i(clk), .rstn_i(rstn), .supply_i(sup),
    .slow_i(slow), .tick_o(tick), .core_good_o(cg), .io_good_o(ig));
  hbs_boot_seq u_hbs_boot_seq (.sys_clk_i(clk), .rstn_i(rstn), .slow_tick_i(tick),
    .wake_load_i(ld), .wake_count_i(cnt), .hibernate_req_i(req), .regulator_on_i(wro & en),
    .wake_request_in_i(wk), .core_reg_good_i(cg), .io_reg_good_i(ig), .fuse_wr_i(wr),
    .fuse_all_i(all), .fuse_addr_i(addr), .fuse_wdata_i(wd), .fuse_rd_i(rd),
    .fuse_rdata_o(rdat), .fuse_rvalid_o(rvld), .wake_reg_out_o(wro), .hibernate_act_o(hact),
    .pmu_trim_o(trim), .pkg_sel_o(pkg), .mem_size_o(mem), .core_pwr_o(cpw),
    .xtal_en_o(xen), .cpu_run_o(run), .soc_rstn_o(srst), .boot_state_o(st));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task stop_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task booted;
    repeat (200) if (run !== 1'h1) @(negedge clk);
  endtask
  task fw(input logic [9:0] a, input logic [7:0] d, input logic f);
    @(negedge clk);
    {addr, wd, all, wr} = {a, d, f, 1'h1};
    @(negedge clk);
    wr = 0;
  endtask
  task fr(input logic [9:0] a, input logic [7:0] e);
    @(negedge clk);
    {addr, rd} = {a, 1'h1};
    @(negedge clk);
    rd = 0;
    chk("rvalid", 8'h01, {7'h00, rvld});
    chk("fuse", e, rdat);
  endtask
  task t_fuse;
    fr(10'h2ff, 8'h00);
    fw(10'h001, 8'ha5, 0);
    fw(10'h001, 8'h5a, 0);
    fr(10'h001, 8'hff);
    fw(10'h000, 8'h03, 1);
    fr(10'h002, 8'h03);
    fr(10'h001, 8'hff);
  endtask
  task t_load(input logic [31:0] n);
    @(negedge clk);
    {ld, cnt} = {1'h1, n};
    @(negedge clk);
    ld = 0;
    repeat (20) if (tick !== 1'h1) @(negedge clk);
    @(negedge clk);
    req = 1;
    @(negedge clk);
    req = 0;
    repeat (3) @(negedge clk);
  endtask
  task t_hib(input logic [31:0] n);
    int k;
    k = 0;
    t_load(n);
    chk("wake_low", 8'h00, {7'h00, wro});
    chk("hibernate_on", 8'h01, {7'h00, hact});
    chk("core_asleep", 8'h00, {7'h00, cpw});
    repeat (200) if (wro === 1'h0) begin
      k += tick;
      @(negedge clk);
    end
    chk("ticks", n[7:0], k[7:0]);
    chk("wake_high", 8'h01, {7'h00, wro});
    chk("hibernate_off", 8'h00, {7'h00, hact});
  endtask
  task t_wake;
    en = 0;
    slow = 1;
    repeat (3) @(negedge clk);
    chk("run_off", 8'h00, {7'h00, run});
    chk("state_off", 8'h00, {5'h00, st});
    wk = 1;
    booted;
    chk("run_on", 8'h01, {7'h00, run});
    chk("soc_rst", 8'h01, {7'h00, srst});
  endtask
  task t_reset;
    @(negedge clk);
    rstn = 0;
    repeat (6) @(negedge clk);
    chk("rst_run", 8'h00, {7'h00, run});
    chk("rst_wake", 8'h01, {7'h00, wro});
    rstn = 1;
    booted;
    fr(10'h001, 8'hff);
    chk("rst_pkg", 8'hff, pkg);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1;
    booted;
    chk("trim_blank", 8'h00, trim);
    chk("core_on", 8'h01, {7'h00, cpw});
    chk("xtal", 8'h01, {7'h00, xen});
    chk("state_run", 8'h05, {5'h00, st});
    t_fuse;
    t_load(32'h0000_0000);
    chk("zero_count", 8'h01, {7'h00, wro});
    t_hib(32'h0000_0003);
    booted;
    chk("pkg", 8'hff, pkg);
    chk("trim", 8'h03, trim);
    chk("mem", 8'h03, mem);
    t_reset;
    t_wake;
    stop_test;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
endmodule // testbench
